// >>> sdd_cfg.svh
// Purpose: Constants of the stereo decimator and serial sample port
// Assumes: Master clock of 125 MHz on CLK_I
// Notes:   Definitions only
`ifndef SDD_CFG_SVH
`define SDD_CFG_SVH
`define SDD_DIV256      3'h4
`define SDD_DIV384      3'h6
`define SDD_TAPS_M1     13'h11FF
`define SDD_FULL_POS    16'h7FFF
`define SDD_FULL_NEG    16'h8000
`define SDD_SAT_HI      18'sh0_7FFF
`define SDD_SAT_LO      18'sh3_8000
`define SDD_RUN_LEN     7'h40
`define SDD_CLK_NS      8
`define SDD_RECOVER_NS  5000
`define SDD_RECOVER_CYC 10'(`SDD_RECOVER_NS / `SDD_CLK_NS)
`define SDD_REG_CTRL    8'h00
`define SDD_REG_STAT    8'h04
`define SDD_REG_LEFT    8'h08
`define SDD_REG_RIGHT   8'h0C
`define SDD_CTRL_MUTE   0
`define SDD_CTRL_RESET  1'h0
`define SDD_RESP_OKAY   2'h0
`define SDD_RESP_SLVERR 2'h2
`endif

// >>> sdd_decim_serial.sv
// Purpose: Stereo one-bit decimator with pin-configured serial sample output
// Assumes: Master mode; modulator bits arrive synchronous to CLK_I
// Notes:   Boxcar FIR of 4608 taps, 64 bit slots per frame, 32 in the packed format
// Function
// RULE1: Two's-complement words, MSB shifted out first
// RULE2: Format chosen by static pins only
// RULE3: Wide frame: right, I2S, left, strobe positions
// RULE4: Packed frame: both words in 32 slots
// RULE5: One word pair per word period
// RULE6: Left and right share one serial output
// RULE7: One-bit stream per channel at 64x rate
// RULE8: Delay line advances once per modulator tick
// RULE9: Symmetric FIR coefficients, linear phase
// RULE10: Transition band, stopband, ripple figures
// RULE11: Latency thirty-six word periods
// RULE12: Overdrive resets modulator, recovers within 5 us
// RULE13: Overdrive saturates at full-scale codes
// RULE14: Divide master clock by 4 or 6
// RULE15: Reset clears filter and output buffer
// RULE16: Master mode derives bit and frame clocks
// RULE17: MSB delay pin delays first bit one slot; the code ignores the pin in the right-justified and strobe formats
// RULE18: Unused wide-frame slots driven low
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "sdd_cfg.svh"
module sdd_decim_serial
  import sdd_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        RATIO_384_I,
  input  wire logic        PACKED_I,
  input  wire logic        STROBE_MODE_I,
  input  wire logic        JUSTIFY_SIDE_SELECT_I,
  input  wire logic        MSB_DELAY_SELECT_I,
  input  wire logic        WORD_STROBE_I,
  input  wire logic        MOD_L_I,
  input  wire logic        MOD_R_I,
  output logic             MOD_CLK_O,
  output logic             MOD_RESET_O,
  output logic             BIT_CLOCK_O,
  output logic             CHANNEL_FRAME_CLOCK_O,
  output logic             SERIAL_SAMPLE_OUT_O,
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I
);
  function automatic logic [15:0] sat16(input logic signed [13:0] v);
    logic signed [17:0] e;
    logic signed [17:0] s;
    e = {{4{v[13]}}, v};
    s = (e <<< 3) - e + (e >>> 3);
    if (s > `SDD_SAT_HI)
      sat16 = `SDD_FULL_POS;
    else if (s < `SDD_SAT_LO)
      sat16 = `SDD_FULL_NEG;
    else
      sat16 = s[15:0];
  endfunction

  sdd_fmt_t          fmt;
  logic [2:0]        div;
  logic [2:0]        div_cnt, next_div_cnt;
  logic [5:0]        tick_cnt, next_tick_cnt;
  logic [5:0]        nt;
  logic              mclk, next_mclk, bclk, next_bclk, channel_frame_clock, next_channel_frame_clock;
  logic              mod_tick, frame_end, slot_tick;
  logic [1:0]        line_mem [0:4607];
  logic [1:0]        din, old;
  logic [12:0]       ptr, next_ptr;
  logic              fill, next_fill;
  logic signed [13:0] x [2];
  logic signed [13:0] next_x [2];
  logic [6:0]        run [2];
  logic [6:0]        next_run [2];
  logic [1:0]        prev_in, next_prev_in;
  logic [9:0]        rec, next_rec;
  logic [15:0]       wl, wr, next_wl, next_wr;
  logic              serial_sample_out, next_serial_sample_out, prev_lsb, next_prev_lsb;
  logic [4:0]        sk, next_sk, cur, kk;
  logic [5:0]        pw;
  logic [4:0]        pp;
  logic              mute, next_mute;
  logic              aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0]        aw_addr, next_aw_addr, ar_addr;
  logic [31:0]       w_data, next_w_data, next_rdata;
  logic              w_b0, next_w_b0;
  logic              bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]        bresp, next_bresp, rresp, next_rresp;
  logic [31:0]       rdata;

  // Format comes from pins only; nothing on the bus can change it
  assign fmt = PACKED_I ? SDD_FMT_PACKED : STROBE_MODE_I ? SDD_FMT_STROBE :  // RULE2
               JUSTIFY_SIDE_SELECT_I ? SDD_FMT_RIGHT : SDD_FMT_LEFT;
  assign div = RATIO_384_I ? `SDD_DIV384 : `SDD_DIV256;  // RULE14
  // Compare with >= so a ratio change mid-count cannot stall the divider
  assign mod_tick = (div_cnt >= div - 3'h1);
  assign nt = tick_cnt + 6'h01;
  assign frame_end = mod_tick && (nt == 6'h00);  // RULE5
  assign slot_tick = mod_tick && (!PACKED_I || !nt[0]);

  always_comb
  begin
    next_div_cnt = mod_tick ? 3'h0 : div_cnt + 3'h1;
    next_mclk = (next_div_cnt >= (div >> 1));
    next_tick_cnt = mod_tick ? nt : tick_cnt;
    next_bclk = PACKED_I ? (mod_tick ? nt[0] : bclk) : next_mclk;  // RULE16
    next_channel_frame_clock = mod_tick ? ~nt[5] : channel_frame_clock;  // RULE6
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      div_cnt <= 3'h0;
      tick_cnt <= 6'h00;
      mclk <= 1'h0;
      bclk <= 1'h0;
      channel_frame_clock <= 1'h0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      tick_cnt <= next_tick_cnt;
      mclk <= next_mclk;
      bclk <= next_bclk;
      channel_frame_clock <= next_channel_frame_clock;
    end
  end

  // Delay line: unwritten taps count as midscale until the first wrap
  assign din = {MOD_R_I, MOD_L_I};  // RULE7
  assign old = line_mem[ptr];

  always_comb
  begin
    next_ptr = ptr;
    next_fill = fill;
    next_prev_in = prev_in;
    next_rec = (rec != 10'h000) ? rec - 10'h001 : rec;
    next_wl = wl;
    next_wr = wr;
    for (int c = 0; c < 2; c++)
    begin
      next_x[c] = x[c];
      next_run[c] = run[c];
    end
    if (mod_tick)
    begin
      next_ptr = (ptr == `SDD_TAPS_M1) ? 13'h0000 : ptr + 13'h0001;  // RULE8
      next_fill = fill || (ptr == `SDD_TAPS_M1);
      next_prev_in = din;
      for (int c = 0; c < 2; c++)
      begin
        // Equal taps make the response symmetric about the midpoint
        next_x[c] = x[c] + (din[c] ? 14'sh0001 : 14'sh3FFF);  // RULE9
        if (fill)
          next_x[c] = next_x[c] - (old[c] ? 14'sh0001 : 14'sh3FFF);  // RULE11
        next_run[c] = (din[c] == prev_in[c] && rec == 10'h000) ?
                      run[c] + 7'h01 : 7'h00;
      end
      // A long run of equal bits means the loop has lost lock
      if (rec == 10'h000 && (run[0] >= `SDD_RUN_LEN || run[1] >= `SDD_RUN_LEN))
        next_rec = `SDD_RECOVER_CYC;  // RULE12
    end
    if (frame_end)
    begin
      next_wl = mute ? 16'h0000 : sat16(x[0]);  // RULE13
      next_wr = mute ? 16'h0000 : sat16(x[1]);
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (mod_tick)
      line_mem[ptr] <= din;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      ptr <= 13'h0000;  // RULE15
      fill <= 1'h0;
      prev_in <= 2'h0;
      rec <= 10'h000;
      wl <= 16'h0000;
      wr <= 16'h0000;
      for (int c = 0; c < 2; c++)
      begin
        x[c] <= 14'sh0000;
        run[c] <= 7'h00;
      end
    end
    else
    begin
      ptr <= next_ptr;
      fill <= next_fill;
      prev_in <= next_prev_in;
      rec <= next_rec;
      wl <= next_wl;
      wr <= next_wr;
      for (int c = 0; c < 2; c++)
      begin
        x[c] <= next_x[c];
        run[c] <= next_run[c];
      end
    end
  end

  // Bit for the slot that starts at the coming tick; words are MSB first
  always_comb
  begin
    next_serial_sample_out = serial_sample_out;
    next_sk = sk;
    // Keep the LSB of the word just latched, so the spill lands in the following frame
    next_prev_lsb = frame_end ? next_wr[0] : prev_lsb;
    pw = nt - {5'h00, MSB_DELAY_SELECT_I};  // RULE17
    pp = nt[5:1] - {4'h0, MSB_DELAY_SELECT_I};
    cur = (nt[4:0] == 5'h00) ? 5'h10 : sk;
    kk = (cur < 5'h10) ? cur + 5'h01 : cur;
    if (cur == 5'h0F)
      kk = 5'h11;
    if (cur == 5'h10 && WORD_STROBE_I)
      kk = 5'h00;
    if (slot_tick)
    begin
      case (fmt)
        SDD_FMT_LEFT:
          next_serial_sample_out = !pw[4] && (pw[5] ? next_wr[~pw[3:0]] : next_wl[~pw[3:0]]);  // RULE3
        SDD_FMT_RIGHT:
          next_serial_sample_out = nt[4] && (nt[5] ? next_wr[~nt[3:0]] : next_wl[~nt[3:0]]);  // RULE18
        SDD_FMT_STROBE:
        begin
          next_sk = kk;
          next_serial_sample_out = !kk[4] && (nt[5] ? next_wr[~kk[3:0]] : next_wl[~kk[3:0]]);
        end
        SDD_FMT_PACKED:
          // With the delay, the right LSB spills into the next frame
          next_serial_sample_out = (nt[5:1] < {4'h0, MSB_DELAY_SELECT_I}) ? prev_lsb :  // RULE4
                      (pp[4] ? next_wr[~pp[3:0]] : next_wl[~pp[3:0]]);  // RULE1
        default:
          next_serial_sample_out = 1'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      serial_sample_out <= 1'h0;
      sk <= 5'h11;
      prev_lsb <= 1'h0;
    end
    else
    begin
      serial_sample_out <= next_serial_sample_out;
      sk <= next_sk;
      prev_lsb <= next_prev_lsb;
    end
  end

  // Bus slave: address and data taken in either order, one write at a time
  assign AWREADY_O = !aw_full && !bvalid;
  assign WREADY_O = !w_full && !bvalid;
  assign ARREADY_O = !rvalid;

  always_comb
  begin
    next_aw_full = aw_full || AWVALID_I;
    next_aw_addr = (AWVALID_I && !aw_full && !bvalid) ? AWADDR_I : aw_addr;
    next_w_full = w_full || WVALID_I;
    next_w_data = (WVALID_I && !w_full && !bvalid) ? WDATA_I : w_data;
    next_w_b0 = (WVALID_I && !w_full && !bvalid) ? WSTRB_I[0] : w_b0;
    if (bvalid)
    begin
      next_aw_full = aw_full;
      next_w_full = w_full;
    end
    next_mute = mute;
    next_bvalid = bvalid && !BREADY_I;
    next_bresp = bresp;
    if (aw_full && w_full && !bvalid)
    begin
      next_aw_full = 1'h0;
      next_w_full = 1'h0;
      next_bvalid = 1'h1;
      next_bresp = `SDD_RESP_OKAY;
      if (aw_addr == `SDD_REG_CTRL)
      begin
        if (w_b0)
          next_mute = w_data[`SDD_CTRL_MUTE];
      end
      else if (aw_addr != `SDD_REG_STAT && aw_addr != `SDD_REG_LEFT &&
               aw_addr != `SDD_REG_RIGHT)
        next_bresp = `SDD_RESP_SLVERR;
    end
    ar_addr = ARADDR_I;
    next_rvalid = rvalid && !RREADY_I;
    next_rdata = rdata;
    next_rresp = rresp;
    if (ARVALID_I && !rvalid)
    begin
      next_rvalid = 1'h1;
      next_rresp = `SDD_RESP_OKAY;
      case (ar_addr)
        `SDD_REG_CTRL:  next_rdata = {31'h0000_0000, mute};
        `SDD_REG_STAT:  next_rdata = {28'h000_0000, fmt, fill, MOD_RESET_O};
        `SDD_REG_LEFT:  next_rdata = {16'h0000, wl};
        `SDD_REG_RIGHT: next_rdata = {16'h0000, wr};
        default:
        begin
          next_rdata = 32'h0000_0000;
          next_rresp = `SDD_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      aw_full <= 1'h0;
      aw_addr <= 8'h00;
      w_full <= 1'h0;
      w_data <= 32'h0000_0000;
      w_b0 <= 1'h0;
      mute <= `SDD_CTRL_RESET;
      bvalid <= 1'h0;
      bresp <= `SDD_RESP_OKAY;
      rvalid <= 1'h0;
      rdata <= 32'h0000_0000;
      rresp <= `SDD_RESP_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_b0 <= next_w_b0;
      mute <= next_mute;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign MOD_CLK_O = mclk;
  assign MOD_RESET_O = (rec != 10'h000);
  assign BIT_CLOCK_O = bclk;
  assign CHANNEL_FRAME_CLOCK_O = channel_frame_clock;
  assign SERIAL_SAMPLE_OUT_O = serial_sample_out;
  assign BVALID_O = bvalid;
  assign BRESP_O = bresp;
  assign RVALID_O = rvalid;
  assign RDATA_O = rdata;
  assign RRESP_O = rresp;

  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // Ratio must stand still for a whole spacing, else a pin change would look like a fault
  sequence s_ratio_low5;
    (!RATIO_384_I && !RST_I) [*5];
  endsequence
  sequence s_ratio_high7;
    (RATIO_384_I && !RST_I) [*7];
  endsequence
  sequence s_word_hold;
    $stable(wl) [*8];
  endsequence

  AST_DIV4: assert property (s_ratio_low5 ##0 mod_tick |-> $past(mod_tick, 4) && // RULE14
    !$past(mod_tick, 3) && !$past(mod_tick, 2) && !$past(mod_tick))
    else $error("modulator tick spacing wrong in 256 mode");
  AST_DIV6: assert property (s_ratio_high7 ##0 mod_tick |-> $past(mod_tick, 6) && // RULE14
    !$past(mod_tick, 5) && !$past(mod_tick, 4) && !$past(mod_tick, 3) &&
    !$past(mod_tick, 2) && !$past(mod_tick))
    else $error("modulator tick spacing wrong in 384 mode");
  AST_RESET: assert property ($fell(RST_I) |-> x[0] == 14'sh0000 && !fill && wl == 16'h0000 && !SERIAL_SAMPLE_OUT_O) // RULE15
    else $error("state not cleared by reset");
  AST_RECOVER: assert property ($rose(MOD_RESET_O) |-> ##[1:625] !MOD_RESET_O) // RULE12
    else $error("modulator reset longer than recovery time");
  AST_SAT_POS: assert property (frame_end && !mute && x[0] > 14'sh11F6 |=> wl == `SDD_FULL_POS) // RULE13
    else $error("positive overdrive did not saturate");
  AST_WORD_RATE: assert property (mod_tick && nt == 6'h01 |=> s_word_hold) // RULE5
    else $error("word changed inside a word period");
  AST_MSB_FIRST: assert property (slot_tick && fmt == SDD_FMT_LEFT && !MSB_DELAY_SELECT_I && nt == 6'h00 |=> SERIAL_SAMPLE_OUT_O == wl[15]) // RULE1
    else $error("left word MSB not in first slot");
  AST_PAD_LOW: assert property (slot_tick && fmt == SDD_FMT_RIGHT && !nt[4] |=> !SERIAL_SAMPLE_OUT_O) // RULE18
    else $error("unused slot not driven low");
  AST_FRAME_LEFT: assert property (mod_tick && nt == 6'h00 |=> CHANNEL_FRAME_CLOCK_O [*8]) // RULE6
    else $error("frame clock not high for left half");
  AST_PTR_STEP: assert property (mod_tick && ptr != `SDD_TAPS_M1 |=> ptr == $past(ptr) + 13'h0001) // RULE8
    else $error("delay line pointer did not advance");
  AST_BHOLD: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped early");
endmodule
`default_nettype wire

// >>> sdd_pkg.sv
// Purpose: Types of the stereo decimator and serial sample port
// Assumes: Nothing
// Notes:   Output formats as decoded from the configuration pins
package sdd_pkg;
  typedef enum logic [1:0] {
    SDD_FMT_LEFT   = 2'h0,
    SDD_FMT_RIGHT  = 2'h1,
    SDD_FMT_STROBE = 2'h2,
    SDD_FMT_PACKED = 2'h3
  } sdd_fmt_t;
endpackage

// >>> sdd_rx_model.sv
// Purpose: Receiver model of the serial sample port
// Assumes: Master mode; bit and frame clocks synchronous to clk_i
// Notes:   Frame boundary is the rising frame clock
`timescale 1ns/1ns
`default_nettype none
module sdd_rx_model
(
  input  wire logic        clk_i,
  input  wire logic        bit_clock_i,
  input  wire logic        frame_clock_i,
  input  wire logic        data_i,
  output logic [63:0]      frame_o = 64'h0000_0000_0000_0000,
  output logic [6:0]       nbits_o = 7'h00,
  output logic [15:0]      period_o = 16'h0000
);
  logic [63:0] sr    = 64'h0000_0000_0000_0000;
  logic [6:0]  cnt   = 7'h00;
  logic [15:0] cyc   = 16'h0000;
  logic        bck_q = 1'b0;
  logic        frm_q = 1'b0;

  always @(posedge clk_i)
  begin
    bck_q <= bit_clock_i;
    frm_q <= frame_clock_i;
    cyc   <= (frame_clock_i && !frm_q) ? 16'h0001 : cyc + 16'h0001;
    // Sample on the rising bit clock, first bit lands highest
    if (bit_clock_i && !bck_q)
    begin
      sr  <= {sr[62:0], data_i};
      cnt <= cnt + 7'h01;
    end
    if (frame_clock_i && !frm_q)
    begin
      frame_o  <= sr;
      nbits_o  <= cnt;
      period_o <= cyc;
      cnt      <= 7'h00;
    end
  end
endmodule
`default_nettype wire

// >>> test_stereo_decimator_serial_out.sv
// Purpose: Self-checking bench of the stereo decimator serial port
// Assumes: 125 MHz clock; word strobe follows the frame clock one cycle late
// Notes:   Format pins change mid-run, so a few frames are skipped
`timescale 1ns/1ns
`default_nettype none
`include "sdd_cfg.svh"
module test_stereo_decimator_serial_out;
  import sdd_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ratio = 1'b0, pk = 1'b0, st = 1'b0, js = 1'b0, dl = 1'b0;
  logic        mod_l = 1'b0, mod_r = 1'b0, pat = 1'b0, mclk_q = 1'b0, seen_mr = 1'b0;
  logic        ws = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire         mod_clk, mod_rst, bck, frm, serial_sample_out;
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [63:0]  rx_frame;
  wire [6:0]   rx_nbits;
  wire [15:0]  rx_period;
  int          fails = 0;
  int          n_checks = 0;

  sdd_decim_serial u_dut (.CLK_I(clk), .RST_I(rst), .RATIO_384_I(ratio), .PACKED_I(pk),
    .STROBE_MODE_I(st), .JUSTIFY_SIDE_SELECT_I(js), .MSB_DELAY_SELECT_I(dl),
    .WORD_STROBE_I(ws), .MOD_L_I(mod_l), .MOD_R_I(mod_r), .MOD_CLK_O(mod_clk),
    .MOD_RESET_O(mod_rst), .BIT_CLOCK_O(bck), .CHANNEL_FRAME_CLOCK_O(frm),
    .SERIAL_SAMPLE_OUT_O(serial_sample_out), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready));

  sdd_rx_model u_rx (.clk_i(clk), .bit_clock_i(bck), .frame_clock_i(frm), .data_i(serial_sample_out),
    .frame_o(rx_frame), .nbits_o(rx_nbits), .period_o(rx_period));

  initial
  begin
    forever #4 clk = ~clk;
  end

  // One new modulator bit per tick: alternating is midscale, pat gives full scale
  always @(posedge clk)
  begin
    mclk_q <= mod_clk;
    // Strobe lags the frame clock: left word starts one slot late, right word on time
    ws     <= st & frm;
    if (mod_rst === 1'b1)
      seen_mr <= 1'b1;
    if (mod_clk && !mclk_q)
    begin
      mod_l <= pat ? 1'b1 : ~mod_l;
      mod_r <= pat ? 1'b0 : ~mod_r;
    end
  end

  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      fails++;
    end
  endtask

  task automatic frames(input int n);
    repeat (n * (ratio ? 384 : 256)) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    h = 1'b0;
    for (int t = 0; t < 200 && !h; t++)
    begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
      if (h)
        arvalid <= 1'b0;
    end
    h = 1'b0;
    for (int t = 0; t < 200 && !h; t++)
    begin
      @(negedge clk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (h)
        rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    {ha, hw, hb} = 3'h0;
    for (int t = 0; t < 200 && !hb; t++)
    begin
      @(negedge clk);
      ha = ha | awready;
      hw = hw | wready;
      hb = bvalid;
      r  = bresp;
      @(posedge clk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      if (hb)
        bready <= 1'b0;
    end
  endtask

  function automatic logic [63:0] exp_frame(input logic [3:0] c, input logic [15:0] l,
                                            input logic [15:0] r);
    logic [31:0] p;
    p = {l, r};
    if (c[3])
      return c[0] ? {32'h0000_0000, p[0], p[31:1]} : {32'h0000_0000, p};
    if (c[2])
      return {({l, 16'h0000} >> 1), r, 16'h0000};
    if (c[1])
      return {16'h0000, l, 16'h0000, r};
    return {({l, 16'h0000} >> c[0]), ({r, 16'h0000} >> c[0])};
  endfunction

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`SDD_REG_CTRL, d, r);
    chk("ctrl", d, 0);
    rd(`SDD_REG_STAT, d, r);
    chk("stat", d, 0);
    rd(`SDD_REG_LEFT, d, r);
    chk("left word", d, 0);
    rd(8'h10, d, r);
    chk("unmapped read resp", r, `SDD_RESP_SLVERR);
    chk("unmapped read data", d, 0);
    wr(8'h14, 32'h0000_0001, r);
    chk("unmapped write resp", r, `SDD_RESP_SLVERR);
    wr(`SDD_REG_STAT, 32'h0000_000F, r);
    chk("stat write resp", r, `SDD_RESP_OKAY);
    rd(`SDD_REG_STAT, d, r);
    chk("stat kept", d, 0);
    $display("reset test done");
  endtask

  task automatic t_step;
    logic [31:0] d;
    logic [1:0]  r;
    frames(74);
    rd(`SDD_REG_STAT, d, r);
    chk("line full", d[1], 1);
    rd(`SDD_REG_LEFT, d, r);
    chk("midscale", d[15:0], 0);
    chk("no recovery", seen_mr, 0);
    pat <= 1'b1;
    frames(34);
    rd(`SDD_REG_LEFT, d, r);
    chk("below half", d[15:14], 2'h0);
    frames(4);
    rd(`SDD_REG_LEFT, d, r);
    chk("above half", d[15:14], 2'h1);
    frames(40);
    rd(`SDD_REG_LEFT, d, r);
    chk("left clip", d[15:0], `SDD_FULL_POS);
    rd(`SDD_REG_RIGHT, d, r);
    chk("right clip", d[15:0], `SDD_FULL_NEG);
    chk("recovery seen", seen_mr, 1);
    wr(`SDD_REG_CTRL, 32'h0000_0001, r);
    chk("mute resp", r, `SDD_RESP_OKAY);
    frames(2);
    rd(`SDD_REG_CTRL, d, r);
    chk("mute set", d, 1);
    rd(`SDD_REG_LEFT, d, r);
    chk("muted word", d, 0);
    wr(`SDD_REG_CTRL, 32'h0000_0000, r);
    frames(2);
    rd(`SDD_REG_LEFT, d, r);
    chk("unmuted word", d[15:0], `SDD_FULL_POS);
    $display("filter test done");
  endtask

  task automatic t_formats;
    logic [3:0]  cfg [6] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'h4};
    logic [31:0] d;
    logic [1:0]  r;
    logic [63:0] e;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      {pk, st, js, dl} <= cfg[i];
      frames(3);
      e = exp_frame(cfg[i], `SDD_FULL_POS, `SDD_FULL_NEG);
      chk("frame", cfg[i][3] ? {32'h0000_0000, rx_frame[31:0]} : rx_frame, e);
      chk("slots", rx_nbits, cfg[i][3] ? 32 : 64);
      chk("period", rx_period, 256);
      rd(`SDD_REG_STAT, d, r);
      chk("format", d[3:2], cfg[i][3] ? 3 : cfg[i][2] ? 2 : cfg[i][1] ? 1 : 0);
    end
    @(posedge clk);
    {pk, st, js, dl} <= 4'h0;
    ratio            <= 1'b1;
    @(posedge clk);
    frames(3);
    chk("period 384", rx_period, 384);
    chk("frame 384", rx_frame, exp_frame(4'h0, `SDD_FULL_POS, `SDD_FULL_NEG));
    $display("format test done");
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    fails++;
    results();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_step();
    t_formats();
    results();
  end
endmodule
`default_nettype wire
